// [cpuat_core.sv]
// Access-timing CPU slice: add-with-carry executor, external bus and banked RAM.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps

module cpuat_core
#(
    parameter int NBANKS = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic ext_req,
    output logic ext_we,
    output logic [1:0] ext_space,
    output logic [15:0] ext_addr,
    output logic [15:0] ext_wdata,
    input wire logic [15:0] ext_rdata,
    input wire logic ext_ready
);
    import cpuat_pkg::*;
    localparam int AW = BANK_AW + $clog2(NBANKS);
    localparam logic [16:0] RAM_WORDS = 17'(NBANKS << BANK_AW);
    typedef struct packed {
        cpuat_state_t st;
        logic pready, pslverr, pext, store, carry, bad, pipe, ext_req, ext_we;
        logic [31:0] prdata, acc, cyc, last_cyc;
        logic [7:0] repeat_next_instr, iter, acnt, alen;
        logic [15:0] instr_reg, maddr, paddr, instr, ext_addr, ext_wdata;
        logic [3:0] wp, wd;
        logic [8:0] dp;
        logic [2:0] aux_reg_pointer;
        logic [7:0][15:0] ar;
        logic [1:0] ext_space;
    } cpuat_regs_t;
    cpuat_regs_t s;
    cpuat_regs_t next_s;
    logic [15:0] mem [RAM_WORDS];
    logic acc_done, cpu_rd, mem_we, do_exec, carry_out;
    logic [15:0] rd_iw, rd_addr;
    // Operand address from the instruction word
    function automatic logic [15:0] op_addr(input logic [15:0] iw, input logic [8:0] dpv,
                                            input logic [15:0] arv);
        op_addr = iw[IND_BIT] ? arv : {dpv, iw[DMA_W-1:0]};
    endfunction
    function automatic logic is_int(input logic [15:0] a);
        is_int = {1'b0, a} < RAM_WORDS;
    endfunction
    // ***************************************
    // External access completion
    // ***************************************
    assign acc_done = s.ext_req && ((s.acnt + 8'h01) >= s.alen) && ext_ready;
    // ***************************************
    // Next-state logic
    // ***************************************
    always_comb begin
        logic go_next, lch, lch_we, rd_int, stall;
        logic [1:0] lch_sp;
        logic [15:0] lch_addr, lch_wd, opnd, a2, arv;
        logic [3:0] lch_ws;
        logic [32:0] sum;
        logic [2:0] ar_update_field;
        next_s = s;
        go_next = 1'b0;
        lch = 1'b0;
        lch_we = 1'b0;
        lch_sp = SP_DATA;
        lch_addr = 16'h0000;
        lch_wd = 16'h0000;
        lch_ws = 4'h0;
        do_exec = 1'b0;
        cpu_rd = 1'b0;
        mem_we = 1'b0;
        stall = 1'b0;
        sum = 33'h0;
        a2 = 16'h0000;
        arv = 16'h0000;
        ar_update_field = s.instr[ARU_LSB +: 3];
        rd_iw = (s.st == ST_FETCH) ? ext_rdata : s.instr;
        rd_addr = op_addr(rd_iw, s.dp, s.ar[s.aux_reg_pointer]);
        rd_int = is_int(rd_addr);
        opnd = rd_int ? mem[rd_addr[AW-1:0]] : ext_rdata;
        // Bus hold and access length counter
        if (acc_done) begin
            next_s.ext_req = 1'b0;
        end
        if (s.acnt != 8'hFF) begin
            next_s.acnt = s.acnt + 8'h01;
        end
        if (s.st != ST_IDLE) begin
            next_s.cyc = s.cyc + 32'h1;
        end
        // Sequencer
        case (s.st)
            ST_IDLE: begin
                if (psel && penable && !s.pready && pwrite && paddr == REG_CTRL
                    && pwdata[CTRL_START]) begin
                    next_s.cyc = 32'h1;
                    next_s.bad = 1'b0;
                    next_s.iter = (pwdata[CTRL_RPT_LSB +: 8] == 8'h00) ? 8'h01
                                                                      : pwdata[CTRL_RPT_LSB +: 8];
                    next_s.pipe = pwdata[CTRL_RPT_LSB +: 8] > PIPE_MIN_RPT;
                    next_s.pext = pwdata[CTRL_PEXT];
                    next_s.store = pwdata[CTRL_STORE];
                    if (pwdata[CTRL_PEXT]) begin
                        lch = 1'b1;
                        lch_sp = SP_PROG;
                        lch_addr = s.paddr;
                        lch_ws = s.wp;
                        next_s.st = ST_FETCH;
                    end else begin
                        next_s.instr = s.instr_reg;
                        a2 = op_addr(s.instr_reg, s.dp, s.ar[s.aux_reg_pointer]);
                        lch = !is_int(a2);
                        lch_addr = a2;
                        lch_ws = s.wd;
                        next_s.st = ST_OPER;
                    end
                end
            end
            ST_FETCH: begin
                if (acc_done) begin
                    next_s.instr = ext_rdata;
                    if (rd_int) begin
                        do_exec = 1'b1;  // Operand read overlaps the fetch's last cycle
                        cpu_rd = 1'b1;
                    end else begin
                        lch = 1'b1;
                        lch_addr = rd_addr;
                        lch_ws = s.wd;
                        next_s.st = ST_OPER;
                    end
                end
            end
            ST_OPER: begin
                if (rd_int) begin
                    do_exec = 1'b1;
                    cpu_rd = 1'b1;
                end else begin
                    do_exec = acc_done;
                end
            end
            ST_WRITE: begin
                go_next = acc_done;
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        // Add with carry and aux register update
        if (do_exec) begin
            if (rd_iw[15:8] != ADD_WITH_CARRY_INSTR_OPC) begin
                next_s.bad = 1'b1;
                next_s.iter = 8'h01;
                go_next = 1'b1;
            end else begin
                sum = {1'b0, s.acc} + {17'h0, opnd} + {32'h0, s.carry};
                next_s.acc = sum[31:0];
                next_s.carry = sum[32];
                ar_update_field = rd_iw[ARU_LSB +: 3];
                arv = s.ar[s.aux_reg_pointer];
                if (rd_iw[IND_BIT]) begin
                    case (ar_update_field)
                        ARU_DEC: next_s.ar[s.aux_reg_pointer] = arv - 16'h0001;
                        ARU_INC: next_s.ar[s.aux_reg_pointer] = arv + 16'h0001;
                        ARU_IX_DEC, ARU_BR_DEC: next_s.ar[s.aux_reg_pointer] = arv - s.ar[0];
                        ARU_IX_INC, ARU_BR_INC: next_s.ar[s.aux_reg_pointer] = arv + s.ar[0];
                        default: next_s.ar[s.aux_reg_pointer] = arv;
                    endcase
                    if (rd_iw[N_BIT]) begin
                        next_s.aux_reg_pointer = rd_iw[2:0];
                    end
                end
                if (s.store && !rd_int) begin
                    lch = 1'b1;
                    lch_we = 1'b1;
                    lch_addr = rd_addr;
                    lch_wd = sum[15:0];
                    lch_ws = s.wd;
                    next_s.st = ST_WRITE;
                end else begin
                    go_next = 1'b1;
                end
            end
        end
        // Next iteration or finish
        if (go_next) begin
            if (next_s.iter <= 8'h01) begin  // A foreign opcode ends the job at once
                next_s.st = ST_IDLE;
                next_s.last_cyc = s.cyc;
            end else begin
                next_s.iter = s.iter - 8'h01;
                if (!s.pipe && s.pext) begin
                    lch = 1'b1;  // Short repeats fetch again
                    lch_sp = SP_PROG;
                    lch_addr = s.paddr;
                    lch_ws = s.wp;
                    next_s.st = ST_FETCH;
                end else begin
                    a2 = op_addr(next_s.instr, s.dp, next_s.ar[next_s.aux_reg_pointer]);
                    lch = !is_int(a2);
                    lch_addr = a2;
                    lch_ws = s.wd;
                    next_s.st = ST_OPER;
                end
            end
        end
        // Start an external access; wait states paid per access
        if (lch) begin
            next_s.ext_req = 1'b1;
            next_s.ext_we = lch_we;
            next_s.ext_space = lch_sp;
            next_s.ext_addr = lch_addr;
            next_s.ext_wdata = lch_wd;
            next_s.acnt = 8'h00;
            next_s.alen = (lch_we ? WR_BASE : RD_BASE) + {4'h0, lch_ws}
                          + ((acc_done && s.ext_we != lch_we) ? TURN_EXTRA : 8'h00);
        end
        // APB slave, answer one cycle into the access phase; MDATA waits while the CPU reads that bank
        if (s.pready) begin
            next_s.pready = 1'b0;
        end
        if (psel && penable && !s.pready) begin
            stall = (paddr == REG_MDATA) && cpu_rd
                    && ((s.maddr >> BANK_AW) == (rd_addr >> BANK_AW));
            next_s.pready = !stall;
            next_s.pslverr = 1'b0;
            next_s.prdata = 32'h0;
            if (!stall) begin
                if (paddr[7:5] == REG_AR_PAGE && paddr[1:0] == 2'h0) begin
                    next_s.prdata = {16'h0, s.ar[paddr[4:2]]};
                    if (pwrite && s.st == ST_IDLE) next_s.ar[paddr[4:2]] = pwdata[15:0];
                end else begin
                    case (paddr)
                        REG_CTRL: next_s.prdata = {16'h0, s.repeat_next_instr, 5'h0, s.store, s.pext, 1'b0};
                        REG_INSTR: next_s.prdata = {16'h0, s.instr_reg};
                        REG_WAIT: next_s.prdata = {24'h0, s.wd, s.wp};
                        REG_DP: next_s.prdata = {23'h0, s.dp};
                        REG_ACC: next_s.prdata = s.acc;
                        REG_STAT: next_s.prdata = {25'h0, s.aux_reg_pointer, 1'b0, s.bad, s.carry,
                                                   s.st != ST_IDLE};
                        REG_CYC: next_s.prdata = s.last_cyc;
                        REG_MADDR: next_s.prdata = {16'h0, s.maddr};
                        REG_MDATA: next_s.prdata = {16'h0, mem[s.maddr[AW-1:0]]};
                        REG_PADDR: next_s.prdata = {16'h0, s.paddr};
                        default: next_s.pslverr = 1'b1;
                    endcase
                    if (pwrite && s.st == ST_IDLE) begin
                        case (paddr)
                            REG_CTRL: begin
                                next_s.repeat_next_instr = pwdata[CTRL_RPT_LSB +: 8];
                                if (!pwdata[CTRL_START]) begin
                                    next_s.pext = pwdata[CTRL_PEXT];
                                    next_s.store = pwdata[CTRL_STORE];
                                end
                            end
                            REG_INSTR: next_s.instr_reg = pwdata[15:0];
                            REG_WAIT: begin
                                next_s.wp = pwdata[WAIT_P_LSB +: 4];
                                next_s.wd = pwdata[WAIT_D_LSB +: 4];
                            end
                            REG_DP: next_s.dp = pwdata[8:0];
                            REG_ACC: next_s.acc = pwdata;
                            REG_STAT: begin
                                next_s.carry = pwdata[STAT_CARRY];
                                next_s.aux_reg_pointer = pwdata[STAT_ARP_LSB +: 3];
                            end
                            REG_MADDR: next_s.maddr = pwdata[15:0];
                            REG_MDATA: mem_we = 1'b1;
                            REG_PADDR: next_s.paddr = pwdata[15:0];
                            default: next_s.pslverr = 1'b1;
                        endcase
                    end
                end
            end
        end
    end

    // ***************************************
    // State register and banked RAM
    // ***************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // RAM write port, one access per bank per cycle
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[s.maddr[AW-1:0]] <= pwdata[15:0];
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign ext_req = s.ext_req;
    assign ext_we = s.ext_we;
    assign ext_space = s.ext_space;
    assign ext_addr = s.ext_addr;
    assign ext_wdata = s.ext_wdata;

    // ***************************************
    // Assertions
    // ***************************************
    assign carry_out = do_exec && (rd_iw[15:8] == ADD_WITH_CARRY_INSTR_OPC) && ({1'b0, s.acc} + {17'h0,
                       (is_int(rd_addr) ? mem[rd_addr[AW-1:0]] : ext_rdata)}
                       + {32'h0, s.carry}) > 33'h0FFFFFFFF;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    ready_hold_a: assert property (ext_req && !ext_ready |=> ext_req && $stable(ext_addr))
        else $error("access ended with ready low");
    wr_min_a: assert property (ext_req && ext_we && s.acnt == 8'h00 |=> ext_req)
        else $error("write shorter than two cycles");
    wr_turn_a: assert property (ext_req && ext_we && s.acnt == 8'h00 && $past(acc_done)
        && !$past(ext_we) |-> ext_req ##1 ext_req ##1 ext_req)
        else $error("write after read not three cycles");
    prog_wait_a: assert property (acc_done && ext_space == SP_PROG |-> s.acnt >= {4'h0, s.wp})
        else $error("program wait states skipped");
    bank_excl_a: assert property (!(mem_we && cpu_rd
        && (s.maddr >> BANK_AW) == (rd_addr >> BANK_AW)))
        else $error("two accesses to one bank");
    carry_clr_a: assert property (do_exec && rd_iw[15:8] == ADD_WITH_CARRY_INSTR_OPC && !carry_out |=> !s.carry)
        else $error("carry not cleared");
    arp_load_a: assert property (do_exec && rd_iw[15:8] == ADD_WITH_CARRY_INSTR_OPC && rd_iw[IND_BIT]
        && rd_iw[N_BIT] |=> s.aux_reg_pointer == $past(rd_iw[2:0]))
        else $error("pointer not loaded");
    int_single_a: assert property (s.st == ST_OPER && s.iter == 8'h01 && is_int(rd_addr)
        && !s.pext && s.cyc == 32'h1 |=> s.st == ST_IDLE && s.last_cyc == 32'h1)
        else $error("internal single not one cycle");

    turn_c: cover property (ext_req && ext_we && s.alen == 8'h03);
    pipe_c: cover property (s.pipe && s.pext && s.st == ST_OPER);
    stall_c: cover property (psel && penable && !pready ##1 !pready);
    ready_c: cover property (ext_req && !ext_ready ##1 acc_done);

endmodule

// [cpuat_ext_mem.sv]
// External program and data memory model with ready stretching.
`timescale 1ns/1ps

module cpuat_ext_mem (
    input wire logic pclk,
    input wire logic ext_req,
    input wire logic ext_we,
    input wire logic [1:0] ext_space,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_wdata,
    output logic [15:0] ext_rdata,
    output logic ext_ready,
    input wire logic [3:0] slow,
    output logic [7:0] wr_len
);
    logic [15:0] mem [0:511];
    logic [3:0] cnt = 4'h0;
    logic [7:0] wcnt = 8'h0;
    logic [15:0] last = 16'h0;

    // Ready held low for the first slow cycles of a burst
    assign ext_ready = ext_req && (cnt >= slow);
    // Read data only while a read is asked, scrambled otherwise
    assign ext_rdata = (ext_req && !ext_we) ? mem[{ext_space[0], ext_addr[7:0]}] : ~last;

    // Burst age, write length and storage
    always @(posedge pclk) begin
        cnt <= !ext_req ? 4'h0 : ((cnt == 4'hF) ? cnt : cnt + 4'h1);
        last <= ~last;
        wcnt <= (ext_req && ext_we) ? wcnt + 8'h1 : 8'h0;
        if (ext_req && ext_we && ext_ready) begin
            mem[{ext_space[0], ext_addr[7:0]}] <= ext_wdata;
            wr_len <= wcnt + 8'h1;
        end
    end
endmodule

// [cpuat_pkg.sv]
// Constants and types for the access-timing CPU slice.
package cpuat_pkg;

    // ***************************************
    // Register byte offsets
    // ***************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INSTR = 8'h04;
    localparam logic [7:0] REG_WAIT = 8'h08;
    localparam logic [7:0] REG_DP = 8'h0C;
    localparam logic [7:0] REG_ACC = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_CYC = 8'h18;
    localparam logic [7:0] REG_MADDR = 8'h1C;
    localparam logic [7:0] REG_MDATA = 8'h20;
    localparam logic [7:0] REG_PADDR = 8'h24;
    localparam logic [2:0] REG_AR_PAGE = 3'h2;  // 0x40..0x5C, one word per aux register

    // ***************************************
    // Register fields
    // ***************************************
    localparam int CTRL_START = 0;
    localparam int CTRL_PEXT = 1;
    localparam int CTRL_STORE = 2;
    localparam int CTRL_RPT_LSB = 8;
    localparam int WAIT_P_LSB = 0;
    localparam int WAIT_D_LSB = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_CARRY = 1;
    localparam int STAT_BAD = 2;
    localparam int STAT_ARP_LSB = 4;

    // ***************************************
    // Instruction word layout
    // ***************************************
    localparam logic [7:0] ADD_WITH_CARRY_INSTR_OPC = 8'h60;
    localparam int IND_BIT = 7;
    localparam int DMA_W = 7;
    localparam int ARU_LSB = 4;
    localparam int N_BIT = 3;
    localparam logic [2:0] ARU_NONE = 3'h0;
    localparam logic [2:0] ARU_DEC = 3'h1;
    localparam logic [2:0] ARU_INC = 3'h2;
    localparam logic [2:0] ARU_BR_DEC = 3'h4;
    localparam logic [2:0] ARU_IX_DEC = 3'h5;
    localparam logic [2:0] ARU_IX_INC = 3'h6;
    localparam logic [2:0] ARU_BR_INC = 3'h7;

    // ***************************************
    // Timing and memory figures
    // ***************************************
    localparam logic [7:0] RD_BASE = 8'h01;
    localparam logic [7:0] WR_BASE = 8'h02;
    localparam logic [7:0] TURN_EXTRA = 8'h01;
    localparam logic [7:0] PIPE_MIN_RPT = 8'h02;
    localparam int BANK_AW = 11;
    localparam logic [1:0] SP_PROG = 2'h0;
    localparam logic [1:0] SP_DATA = 2'h1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_OPER = 4'h4,
        ST_WRITE = 4'h8
    } cpuat_state_t;

endpackage

// [cpuat_tb.sv]
// Self-checking bench for the access-timing CPU slice.
`timescale 1ns/1ps

module testbench;
    import cpuat_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, ext_req, ext_we, ext_ready;
    logic [1:0] ext_space;
    logic [15:0] ext_addr, ext_wdata, ext_rdata;
    logic [3:0] slow = 4'h0;
    logic [7:0] wr_len;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int checked = 0;

    // 125 MHz machine clock
    always #4 pclk = ~pclk;

    cpuat_core #(.NBANKS(2)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_req(ext_req), .ext_we(ext_we),
        .ext_space(ext_space), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .ext_ready(ext_ready));
    cpuat_ext_mem i_mem (.pclk(pclk), .ext_req(ext_req), .ext_we(ext_we),
        .ext_space(ext_space), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .ext_ready(ext_ready), .slow(slow), .wr_len(wr_len));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("pready seen", 32'h1, {31'h0, pready});
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    // Start a job and poll until busy drops
    task automatic run(input logic [31:0] ctrl);
        int n;
        apb(1'b1, REG_CTRL, ctrl);
        n = 0;
        do begin
            apb(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rd[STAT_BUSY] !== 1'b0 && n < 200);
        check("job done", 32'h0, {31'h0, rd[STAT_BUSY]});
    endtask

    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        rdchk("stat reset", REG_STAT, 32'h0);
    endtask

    // Direct form, internal code, operand in second bank, carry in and out
    task automatic t_direct;
        apb(1'b1, REG_MADDR, 32'h801);
        apb(1'b1, REG_MDATA, 32'h2);
        apb(1'b1, REG_ACC, 32'h2);
        apb(1'b1, REG_STAT, 32'h2);
        apb(1'b1, REG_DP, 32'h10);
        apb(1'b1, REG_INSTR, 32'h6001);
        run(32'h1);
        rdchk("acc", REG_ACC, 32'h5);
        rdchk("carry clear", REG_STAT, 32'h0);
        rdchk("cycles int", REG_CYC, 32'h1);
        apb(1'b1, REG_ACC, 32'hFFFFFFFF);
        run(32'h1);
        rdchk("acc wrap", REG_ACC, 32'h1);
        rdchk("carry set", REG_STAT, 32'h2);
    endtask

    // External code and operand, p=2 d=3, single then repeated three times
    task automatic t_ext;
        i_mem.mem[9'h010] = 16'h6005;
        i_mem.mem[9'h105] = 16'h0007;
        apb(1'b1, REG_WAIT, 32'h32);
        apb(1'b1, REG_STAT, 32'h0);
        apb(1'b1, REG_ACC, 32'h1);
        apb(1'b1, REG_DP, 32'h20);
        apb(1'b1, REG_PADDR, 32'h10);
        run(32'h3);
        rdchk("acc ext", REG_ACC, 32'h8);
        rdchk("cycles ext", REG_CYC, 32'h7);
        run(32'h303);
        rdchk("acc rpt", REG_ACC, 32'h1D);
        rdchk("cycles rpt", REG_CYC, 32'hF);
        run(32'h203);
        rdchk("cycles short rpt", REG_CYC, 32'hE);
    endtask

    // Store of the sum to the external operand right after its read
    task automatic t_store;
        apb(1'b1, REG_ACC, 32'h10);
        apb(1'b1, REG_INSTR, 32'h6005);
        run(32'h5);
        rdchk("acc store", REG_ACC, 32'h17);
        check("write len", 32'h6, {24'h0, wr_len});
        check("stored", 32'h17, {16'h0, i_mem.mem[9'h105]});
    endtask

    // Memory holds ready low three cycles on an external fetch
    task automatic t_ready;
        i_mem.mem[9'h010] = 16'h6001;
        apb(1'b1, REG_WAIT, 32'h0);
        apb(1'b1, REG_DP, 32'h10);
        apb(1'b1, REG_ACC, 32'h0);
        slow <= 4'h3;
        run(32'h3);
        slow <= 4'h0;
        rdchk("cycles ready", REG_CYC, 32'h4);
        rdchk("acc ready", REG_ACC, 32'h2);
    endtask

    // Indirect form with post-increment and next pointer zero, then a foreign opcode
    task automatic t_ind;
        apb(1'b1, REG_MADDR, 32'h302);
        apb(1'b1, REG_MDATA, 32'h2);
        apb(1'b1, REG_ACC, 32'h2);
        apb(1'b1, REG_STAT, 32'h40);
        apb(1'b1, 8'h50, 32'h302);
        apb(1'b1, REG_INSTR, 32'h60A8);
        run(32'h1);
        rdchk("acc ind", REG_ACC, 32'h4);
        rdchk("aux four", 8'h50, 32'h303);
        rdchk("pointer", REG_STAT, 32'h0);
        apb(1'b1, REG_INSTR, 32'h6101);
        run(32'h301);
        rdchk("bad flag", REG_STAT, 32'h4);
        rdchk("bad cycles", REG_CYC, 32'h1);
        rdchk("acc kept", REG_ACC, 32'h4);
    endtask

    // Main sequence after eight cycles of reset
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_direct();
        t_ext();
        t_store();
        t_ready();
        t_ind();
        stop_test();
    end

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule
